// ===== csp_checker.sv
// Port assertions for the setup and protection block
`timescale 1ns/1ps
module csp_checker
  import csp_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic autoret_out,
  input wire logic adj_visible_out,
  input wire logic other_items_visible_out,
  input wire logic [26:0] total_out,
  input wire csp_level_t level_out,
  input wire csp_comm_t comm_active_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside its cycle");
  a_total_range: assert property (total_out <= CSP_TOTAL_MAX)
    else $error("totalizer past eight digits");
  a_comm_frozen: assert property ($past(reset_n_in, 2) |-> $stable(comm_active_out))
    else $error("active comm changed without power-up");
  a_unit_range: assert property (comm_active_out.unit_number <= CSP_UNIT_MAX)
    else $error("unit number out of range");
  a_parity_legal: assert property (comm_active_out.parity_select != 2'h3)
    else $error("illegal parity code");
  a_level_onehot: assert property ($onehot(level_out))
    else $error("level not one-hot");
  a_autoret_oper: assert property (autoret_out |-> ##[0:1] level_out == CSP_LV_OPER)
    else $error("auto-return left level");
  a_adj_skip: assert property (!adj_visible_out [*2] |-> level_out != CSP_LV_ADJ)
    else $error("hidden adjustment level entered");
  a_adj_other: assert property (adj_visible_out |-> other_items_visible_out)
    else $error("adjustment shown with items hidden");
endmodule : csp_checker
bind csp_setup_protect csp_checker csp_checker_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .autoret_out(autoret_out),
  .adj_visible_out(adj_visible_out), .other_items_visible_out(other_items_visible_out),
  .total_out(total_out), .level_out(level_out), .comm_active_out(comm_active_out));

// ===== csp_host_panel.sv
// Model of the key controller and serial host on the register port
`timescale 1ns/1ps
module csp_host_panel
(
  input wire logic clk_in,
  input wire logic [31:0] reg_rdata_out,
  output logic [3:0] reg_addr_out,
  output logic [31:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic from_host_out
);
  initial
  begin
    reg_addr_out = 4'h0;
    reg_wdata_out = 32'h0;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    from_host_out = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic h);
    @(posedge clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    from_host_out <= h;
    reg_wr_out <= 1'b1;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    reg_wdata_out <= ~d;
    @(posedge clk_in);
  endtask : wr
  // Host reads need no permission
  task automatic rd(input logic [3:0] a, input logic h, output logic [31:0] d);
    @(posedge clk_in);
    reg_addr_out <= a;
    from_host_out <= h;
    reg_rd_out <= 1'b1;
    @(posedge clk_in);
    reg_rd_out <= 1'b0;
    @(posedge clk_in);
    d = reg_rdata_out;
  endtask : rd
endmodule : csp_host_panel

// ===== csp_pkg.sv
// Package: constants, encodings and carriers for counter setup/protection logic
package csp_pkg;

  // ==========================================================
  // Register offsets (word index on plain port)
  localparam logic [3:0] CSP_REG_SETUP = 4'h0;
  localparam logic [3:0] CSP_REG_PRESCALE = 4'h1;
  localparam logic [3:0] CSP_REG_ADV = 4'h2;
  localparam logic [3:0] CSP_REG_PROTECT = 4'h3;
  localparam logic [3:0] CSP_REG_COMM = 4'h4;
  localparam logic [3:0] CSP_REG_LEVEL = 4'h5;
  localparam logic [3:0] CSP_REG_COUNT = 4'h6;
  localparam logic [3:0] CSP_REG_TOTAL = 4'h7;
  localparam logic [3:0] CSP_REG_COMM_ACT = 4'h8;
  localparam logic [3:0] CSP_REG_PASSWORD = 4'h9;
  localparam logic [3:0] CSP_REG_STATUS = 4'hA;

  // ==========================================================
  // Ranges and defaults
  localparam logic [13:0] CSP_PRESCALE_MIN = 14'h0001;
  localparam logic [13:0] CSP_PRESCALE_MAX = 14'h270F;
  localparam logic [13:0] CSP_PRESCALE_DEF = 14'h03E8;
  localparam logic [1:0] CSP_DP_MAX = 2'h3;
  localparam logic [6:0] CSP_AUTORET_MAX_S = 7'h63;
  localparam logic [4:0] CSP_HOLD_MIN_S = 5'h03;
  localparam logic [4:0] CSP_HOLD_MAX_S = 5'h1E;
  localparam logic [4:0] CSP_HOLD_DEF_S = 5'h03;
  localparam logic [1:0] CSP_OAPT_MAX = 2'h3;
  localparam logic [1:0] CSP_LOCK_MAX = 2'h2;
  localparam logic [1:0] CSP_LOCK_DEF = 2'h1;
  localparam logic [6:0] CSP_UNIT_MAX = 7'h63;
  localparam logic [6:0] CSP_UNIT_DEF = 7'h01;
  localparam logic [15:0] CSP_PASSWORD = 16'hFF57;
  localparam logic [26:0] CSP_TOTAL_MAX = 27'h5F5E0FF;
  localparam logic [9:0] CSP_PV_MIN = 10'h3E7;

  // ==========================================================
  // Timing: one second tick at 200 MHz
  localparam int CSP_CLK_HZ = 200000000;
  localparam int CSP_SECOND_S = 1;
  localparam int CSP_SECOND_CYC = CSP_CLK_HZ * CSP_SECOND_S;

  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    CSP_IN_INC = 2'h0,
    CSP_IN_DEC = 2'h1,
    CSP_IN_INDIV = 2'h2,
    CSP_IN_QUAD = 2'h3
  } csp_in_mode_t;

  typedef enum logic [1:0] {
    CSP_BAUD_1200 = 2'h0,
    CSP_BAUD_2400 = 2'h1,
    CSP_BAUD_4800 = 2'h2,
    CSP_BAUD_9600 = 2'h3
  } csp_baud_t;

  typedef enum logic [1:0] {
    CSP_PAR_NONE = 2'h0,
    CSP_PAR_EVEN = 2'h1,
    CSP_PAR_ODD = 2'h2
  } csp_parity_t;

  typedef enum logic [5:0] {
    CSP_LV_OPER = 6'h01,
    CSP_LV_ADJ = 6'h02,
    CSP_LV_INIT = 6'h04,
    CSP_LV_COMM = 6'h08,
    CSP_LV_ADV = 6'h10,
    CSP_LV_PROT = 6'h20
  } csp_level_t;

  localparam csp_baud_t CSP_BAUD_DEF = CSP_BAUD_9600;
  localparam csp_parity_t CSP_PAR_DEF = CSP_PAR_EVEN;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [6:0] unit_number;
    csp_baud_t baud;
    logic char_bit_length;
    logic stop_bit_count;
    csp_parity_t parity_select;
  } csp_comm_t;

  localparam csp_comm_t CSP_COMM_DEF = '{CSP_UNIT_DEF, CSP_BAUD_DEF, 1'b0, 1'b1, CSP_PAR_DEF};

  typedef struct packed {
    logic [1:0] oper_adj_protect;
    logic [1:0] setup_level_lock;
    logic key_edit_protect;
    logic reset_key_protect;
  } csp_protect_t;

  localparam csp_protect_t CSP_PROTECT_DEF = '{2'h0, CSP_LOCK_DEF, 1'b0, 1'b0};

  typedef struct packed {
    logic timer_sel;
    csp_in_mode_t in_mode;
    logic [1:0] dp_pos;
    logic fall_edge;
  } csp_setup_t;

  localparam csp_setup_t CSP_SETUP_DEF = '{1'b0, CSP_IN_INC, 2'h0, 1'b0};

  typedef struct packed {
    logic total_en;
    logic [6:0] autoret_s;
    logic [4:0] hold_s;
  } csp_adv_t;

  localparam csp_adv_t CSP_ADV_DEF = '{1'b0, 7'h00, CSP_HOLD_DEF_S};

endpackage : csp_pkg

// ===== csp_setup_protect.sv
// Counter setup, protection levels and communication settings
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module csp_setup_protect
  import csp_pkg::*;
#(
  parameter int SECOND_CYC = CSP_SECOND_CYC
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Register port (front panel key controller and serial host bridge)
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_from_host_in,
  output logic [31:0] reg_rdata_out,
  // Front panel events (synchronous one-cycle pulses, level for hold keys)
  input wire logic key_activity_in,
  input wire logic key_protect_pair_in,
  input wire logic key_reset_in,
  input wire logic key_dp_left_in,
  input wire logic key_dp_right_in,
  input wire logic [5:0] level_request_in,
  input wire logic item_change_in,
  // Count pins (asynchronous)
  input wire logic primary_count_input_in,
  input wire logic secondary_gate_input_in,
  // Outputs
  output csp_level_t level_out,
  output logic autoret_out,
  output logic dp_visible_out,
  output logic [1:0] dp_pos_out,
  output logic total_visible_out,
  output logic pv_edit_allowed_out,
  output logic adj_visible_out,
  output logic other_items_visible_out,
  output logic [26:0] total_out,
  output logic [15:0] count_out,
  output csp_comm_t comm_active_out
);

  // ==========================================================
  // Stored settings
  csp_setup_t setup;
  csp_adv_t adv;
  csp_protect_t prot;
  csp_comm_t comm_stored;
  csp_comm_t comm_active;
  logic [13:0] prescale;
  logic host_write_en;
  logic init_armed;
  logic adv_unlocked;
  csp_level_t level;
  logic comm_loaded;

  function automatic logic level_allowed(input csp_level_t lv, input csp_protect_t p,
                                         input logic unlocked);
    case (lv)
      CSP_LV_ADJ: level_allowed = (p.oper_adj_protect == 2'h0);
      CSP_LV_INIT: level_allowed = (p.setup_level_lock != CSP_LOCK_MAX);
      CSP_LV_COMM: level_allowed = (p.setup_level_lock != CSP_LOCK_MAX);
      CSP_LV_ADV: level_allowed = (p.setup_level_lock == 2'h0) && unlocked;
      default: level_allowed = 1'b1;
    endcase
  endfunction : level_allowed

  // ==========================================================
  // Write qualification
  logic wr_ok;
  logic edit_ok;
  logic wr_prot_ok;
  assign wr_ok = reg_wr_in && (!reg_from_host_in || host_write_en);
  assign edit_ok = wr_ok && (reg_from_host_in || !prot.key_edit_protect);
  assign wr_prot_ok = wr_ok && (reg_from_host_in || level == CSP_LV_PROT);

  // ==========================================================
  // Pin synchronisers: three flops, change counts when 2nd and 3rd agree
  logic [2:0] cp_sync;
  logic [2:0] gate_sync;
  logic cp_state;
  logic gate_state;
  logic cp_prev;
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cp_sync <= 3'h0;
      gate_sync <= 3'h0;
      cp_state <= 1'b0;
      gate_state <= 1'b0;
      cp_prev <= 1'b0;
    end
    else
    begin
      cp_sync <= {cp_sync[1:0], primary_count_input_in};
      gate_sync <= {gate_sync[1:0], secondary_gate_input_in};
      if (cp_sync[1] == cp_sync[2])
        cp_state <= cp_sync[2];
      if (gate_sync[1] == gate_sync[2])
        gate_state <= gate_sync[2];
      cp_prev <= cp_state;
    end
  end

  logic edge_hit;
  logic count_step;
  logic inc_dec;
  assign inc_dec = (setup.in_mode == CSP_IN_INC) || (setup.in_mode == CSP_IN_DEC);
  assign edge_hit = setup.fall_edge ? (cp_prev && !cp_state) : (!cp_prev && cp_state);
  assign count_step = !setup.timer_sel && inc_dec && edge_hit && !gate_state;

  // ==========================================================
  // Accumulators: raw count in thousandths, scaled by prescale
  logic [26:0] scaled;
  logic [26:0] total;
  logic [26:0] next_scaled;
  logic reset_clear;
  assign reset_clear = key_reset_in && !prot.reset_key_protect;
  always_comb
  begin
    next_scaled = scaled;
    if (setup.in_mode == CSP_IN_DEC)
      next_scaled = scaled - 27'(prescale);
    else
      next_scaled = scaled + 27'(prescale);
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      scaled <= 27'h0;
      total <= 27'h0;
    end
    else
    begin
      if (reset_clear)
        scaled <= 27'h0;
      else if (count_step)
        scaled <= next_scaled;
      if (reset_clear)
        total <= 27'h0;
      else if (count_step && adv.total_en)
      begin
        if (setup.in_mode == CSP_IN_DEC)
          total <= (total == 27'h0) ? CSP_TOTAL_MAX : total - 27'h1;
        else
          total <= (total == CSP_TOTAL_MAX) ? 27'h0 : total + 27'h1;
      end
    end
  end

  // Whole display units: thousandths shifted by decimal point position
  logic [26:0] disp_div;
  always_comb
  begin
    case (setup.dp_pos)
      2'h0: disp_div = 27'h3E8;
      2'h1: disp_div = 27'h064;
      2'h2: disp_div = 27'h00A;
      default: disp_div = 27'h001;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      count_out <= 16'h0;
    else
      count_out <= 16'(scaled / disp_div);
  end

  // ==========================================================
  // Setup registers
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      setup <= CSP_SETUP_DEF;
      prescale <= CSP_PRESCALE_DEF;
      adv <= CSP_ADV_DEF;
      host_write_en <= 1'b0;
      init_armed <= 1'b0;
    end
    else if (init_armed && item_change_in)
    begin
      setup <= CSP_SETUP_DEF;
      prescale <= CSP_PRESCALE_DEF;
      adv <= CSP_ADV_DEF;
      host_write_en <= 1'b0;
      init_armed <= 1'b0;
    end
    else
    begin
      if (!setup.timer_sel && !prot.key_edit_protect)
      begin
        if (key_dp_left_in && setup.dp_pos != CSP_DP_MAX)
          setup.dp_pos <= setup.dp_pos + 2'h1;
        else if (key_dp_right_in && setup.dp_pos != 2'h0)
          setup.dp_pos <= setup.dp_pos - 2'h1;
      end
      if (edit_ok && reg_addr_in == CSP_REG_SETUP)
      begin
        setup.timer_sel <= reg_wdata_in[0];
        setup.in_mode <= csp_in_mode_t'(reg_wdata_in[2:1]);
        if (!reg_wdata_in[0])
          setup.dp_pos <= reg_wdata_in[4:3];
        if (reg_wdata_in[2:1] == 2'h0 || reg_wdata_in[2:1] == 2'h1)
          setup.fall_edge <= reg_wdata_in[5];
        host_write_en <= reg_wdata_in[8];
      end
      if (edit_ok && reg_addr_in == CSP_REG_PRESCALE && !setup.timer_sel &&
          reg_wdata_in[13:0] >= CSP_PRESCALE_MIN && reg_wdata_in[13:0] <= CSP_PRESCALE_MAX)
        prescale <= reg_wdata_in[13:0];
      if (edit_ok && reg_addr_in == CSP_REG_ADV && level_allowed(CSP_LV_ADV, prot, adv_unlocked))
      begin
        adv.total_en <= reg_wdata_in[0];
        if (reg_wdata_in[7:1] <= CSP_AUTORET_MAX_S)
          adv.autoret_s <= reg_wdata_in[7:1];
        if (reg_wdata_in[12:8] >= CSP_HOLD_MIN_S && reg_wdata_in[12:8] <= CSP_HOLD_MAX_S)
          adv.hold_s <= reg_wdata_in[12:8];
        init_armed <= reg_wdata_in[16];
      end
    end
  end

  // ==========================================================
  // Protection and communication settings
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      prot <= CSP_PROTECT_DEF;
      comm_stored <= CSP_COMM_DEF;
    end
    else if (init_armed && item_change_in)
    begin
      prot <= CSP_PROTECT_DEF;
      comm_stored <= CSP_COMM_DEF;
    end
    else
    begin
      if (wr_prot_ok && reg_addr_in == CSP_REG_PROTECT)
      begin
        if (reg_wdata_in[1:0] <= CSP_OAPT_MAX)
          prot.oper_adj_protect <= reg_wdata_in[1:0];
        if (reg_wdata_in[3:2] <= CSP_LOCK_MAX)
          prot.setup_level_lock <= reg_wdata_in[3:2];
        prot.key_edit_protect <= reg_wdata_in[4];
        prot.reset_key_protect <= reg_wdata_in[5];
      end
      if (edit_ok && reg_addr_in == CSP_REG_COMM && level_allowed(CSP_LV_COMM, prot, 1'b0))
      begin
        if (reg_wdata_in[6:0] <= CSP_UNIT_MAX)
          comm_stored.unit_number <= reg_wdata_in[6:0];
        comm_stored.baud <= csp_baud_t'(reg_wdata_in[9:8]);
        comm_stored.char_bit_length <= reg_wdata_in[10];
        comm_stored.stop_bit_count <= reg_wdata_in[11];
        if (reg_wdata_in[13:12] != 2'h3)
          comm_stored.parity_select <= csp_parity_t'(reg_wdata_in[13:12]);
      end
    end
  end

  // Active settings latched once after power-up release
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      comm_active <= CSP_COMM_DEF;
      comm_loaded <= 1'b0;
    end
    else if (!comm_loaded)
    begin
      comm_active <= comm_stored;
      comm_loaded <= 1'b1;
    end
  end
  assign comm_active_out = comm_active;

  // ==========================================================
  // Timebase and key timers
  logic [27:0] sec_cnt;
  logic sec_tick;
  logic [6:0] idle_s;
  logic [4:0] hold_cnt;
  assign sec_tick = (sec_cnt == 28'(SECOND_CYC - 1));
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      sec_cnt <= 28'h0;
    else if (sec_tick)
      sec_cnt <= 28'h0;
    else
      sec_cnt <= sec_cnt + 28'h1;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      idle_s <= 7'h0;
    else if (key_activity_in)
      idle_s <= 7'h0;
    else if (sec_tick && idle_s != '1)
      idle_s <= idle_s + 7'h1;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      hold_cnt <= 5'h0;
    else if (!key_protect_pair_in || level != CSP_LV_OPER)
      hold_cnt <= 5'h0;
    else if (sec_tick && hold_cnt != '1)
      hold_cnt <= hold_cnt + 5'h1;
  end

  logic autoret_hit;
  logic hold_hit;
  // Free-running tick: one extra tick so a whole set time has surely passed
  assign autoret_hit = (adv.autoret_s != 7'h0) && (idle_s > adv.autoret_s) &&
                       !key_activity_in;
  assign hold_hit = key_protect_pair_in && (hold_cnt > adv.hold_s);

  // ==========================================================
  // Level navigation
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      level <= CSP_LV_OPER;
      adv_unlocked <= 1'b0;
      autoret_out <= 1'b0;
    end
    else
    begin
      autoret_out <= 1'b0;
      if (edit_ok && reg_addr_in == CSP_REG_PASSWORD && level == CSP_LV_INIT)
        adv_unlocked <= (reg_wdata_in[15:0] == CSP_PASSWORD);
      else if (level != CSP_LV_INIT && level != CSP_LV_ADV)
        adv_unlocked <= 1'b0;
      case (level)
        CSP_LV_OPER:
        begin
          if (hold_hit)
            level <= CSP_LV_PROT;
          else if (level_request_in != 6'h0 &&
                   level_allowed(csp_level_t'(level_request_in), prot, adv_unlocked))
            level <= csp_level_t'(level_request_in);
        end
        CSP_LV_ADJ, CSP_LV_INIT, CSP_LV_COMM, CSP_LV_ADV, CSP_LV_PROT:
        begin
          if (autoret_hit && (level == CSP_LV_ADJ))
          begin
            level <= CSP_LV_OPER;
            autoret_out <= 1'b1;
          end
          else if (!level_allowed(level, prot, adv_unlocked))
            level <= CSP_LV_OPER;
          else if (level_request_in != 6'h0 &&
                   level_allowed(csp_level_t'(level_request_in), prot, adv_unlocked))
            level <= csp_level_t'(level_request_in);
        end
        default: level <= CSP_LV_OPER;
      endcase
    end
  end

  // ==========================================================
  // Visibility outputs
  assign level_out = level;
  assign dp_visible_out = !setup.timer_sel;
  assign dp_pos_out = setup.dp_pos;
  assign total_visible_out = adv.total_en;
  assign total_out = total;
  assign adj_visible_out = (prot.oper_adj_protect == 2'h0);
  assign other_items_visible_out = (prot.oper_adj_protect < 2'h2);
  assign pv_edit_allowed_out = (prot.oper_adj_protect != CSP_OAPT_MAX) &&
                               !prot.key_edit_protect;

  // ==========================================================
  // Read port: data one cycle after strobe, reads never gated
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      reg_rdata_out <= 32'h0;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        CSP_REG_SETUP: reg_rdata_out <= {23'h0, host_write_en, 2'h0, setup.fall_edge,
                                         setup.dp_pos, setup.in_mode, setup.timer_sel};
        CSP_REG_PRESCALE: reg_rdata_out <= {18'h0, prescale};
        CSP_REG_ADV: reg_rdata_out <= {15'h0, init_armed, 3'h0, adv.hold_s, adv.autoret_s,
                                       adv.total_en};
        CSP_REG_PROTECT: reg_rdata_out <= {26'h0, prot.reset_key_protect,
                                           prot.key_edit_protect, prot.setup_level_lock,
                                           prot.oper_adj_protect};
        CSP_REG_COMM: reg_rdata_out <= {18'h0, comm_stored.parity_select,
                                        comm_stored.stop_bit_count,
                                        comm_stored.char_bit_length, comm_stored.baud,
                                        1'b0, comm_stored.unit_number};
        CSP_REG_LEVEL: reg_rdata_out <= {25'h0, adv_unlocked, level};
        CSP_REG_COUNT: reg_rdata_out <= {5'h0, scaled};
        CSP_REG_TOTAL: reg_rdata_out <= {5'h0, total};
        CSP_REG_COMM_ACT: reg_rdata_out <= {18'h0, comm_active.parity_select,
                                            comm_active.stop_bit_count,
                                            comm_active.char_bit_length, comm_active.baud,
                                            1'b0, comm_active.unit_number};
        default: reg_rdata_out <= 32'h0;
      endcase
    end
    else
      reg_rdata_out <= 32'h0;
  end

endmodule : csp_setup_protect

// ===== tb_top.sv
// Self-checking bench for the setup and protection block
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb_top
  import csp_pkg::*;
;
  localparam int SEC = 20;
  logic clk_in, reset_n_in, k_act, k_pair, k_rst, k_l, k_r, k_item, cp, gate;
  logic wr, rd, hst, dpv, totv, pve, adjv, othv, aret;
  logic [3:0] addr;
  logic [31:0] wd, rdata, d;
  logic [5:0] lreq;
  logic [26:0] tot;
  logic [15:0] cnt, ps;
  logic [1:0] dpp;
  csp_level_t lvl;
  csp_comm_t cact, c;
  int bad_count = 0, total_checks = 0, n, i;
  csp_host_panel p (.clk_in(clk_in), .reg_rdata_out(rdata), .reg_addr_out(addr),
    .reg_wdata_out(wd), .reg_wr_out(wr), .reg_rd_out(rd), .from_host_out(hst));
  csp_setup_protect #(.SECOND_CYC(SEC)) csp_setup_protect_i (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_from_host_in(hst), .reg_rdata_out(rdata), .key_activity_in(k_act),
    .key_protect_pair_in(k_pair), .key_reset_in(k_rst), .key_dp_left_in(k_l),
    .key_dp_right_in(k_r), .level_request_in(lreq), .item_change_in(k_item),
    .primary_count_input_in(cp), .secondary_gate_input_in(gate), .level_out(lvl),
    .autoret_out(aret), .dp_visible_out(dpv), .dp_pos_out(dpp), .total_visible_out(totv),
    .pv_edit_allowed_out(pve), .adj_visible_out(adjv), .other_items_visible_out(othv),
    .total_out(tot), .count_out(cnt), .comm_active_out(cact));
  function automatic logic [31:0] comm_word(csp_comm_t x);
    return {18'h0, x.parity_select, x.stop_bit_count, x.char_bit_length, x.baud, 1'b0,
      x.unit_number};
  endfunction : comm_word
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic pulse(input int k);
    repeat (k)
    begin
      cp <= 1'b1;
      repeat (6) @(posedge clk_in);
      cp <= 1'b0;
      repeat (6) @(posedge clk_in);
    end
  endtask : pulse
  task automatic req(input csp_level_t l);
    @(posedge clk_in);
    lreq <= l;
    k_act <= 1'b1;
    @(posedge clk_in);
    lreq <= 6'h0;
    k_act <= 1'b0;
  endtask : req
  task automatic goto_prot();
    k_pair <= 1'b1;
    for (n = 0; n < 8 * SEC && lvl !== CSP_LV_PROT; n++) @(posedge clk_in);
    `CHK("hold_span", 1'b1, n >= 3 * SEC)
    `CHK("prot_lvl", CSP_LV_PROT, lvl)
    k_pair <= 1'b0;
  endtask : goto_prot
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial
  begin
    #(5 * 30000);
    bad_count++;
    close_out();
  end
  initial
  begin
    {reset_n_in, k_act, k_pair, k_rst, k_l, k_r, k_item, cp, gate} = 9'h0;
    lreq = 6'h0;
    n = $urandom(32'hDBF8);
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    p.rd(CSP_REG_PROTECT, 1'b0, d);
    `CHK("lock", 2'h1, d[3:2])
    `CHK("comm_act", CSP_COMM_DEF, cact)
    for (i = 0; i < 4; i++)
    begin
      c = '{7'($urandom % 100), csp_baud_t'(i), i[0], i[1], csp_parity_t'(i % 3)};
      p.wr(CSP_REG_COMM, comm_word(c), 1'b0);
      p.rd(CSP_REG_COMM, 1'b0, d);
      `CHK("comm", comm_word(c), d)
      `CHK("comm_act", CSP_COMM_DEF, cact)
    end
    $display("test comm done");
    p.wr(CSP_REG_ADV, 32'h303, 1'b0);
    p.rd(CSP_REG_ADV, 1'b0, d);
    `CHK("adv_lock", 32'h300, d)
    goto_prot();
    p.wr(CSP_REG_PROTECT, 32'h0, 1'b0);
    req(CSP_LV_INIT);
    p.wr(CSP_REG_PASSWORD, {16'h0, CSP_PASSWORD}, 1'b0);
    p.wr(CSP_REG_ADV, 32'h303, 1'b0);
    p.rd(CSP_REG_ADV, 1'b0, d);
    `CHK("adv", 32'h303, d)
    `CHK("tot_vis", 1'b1, totv)
    req(CSP_LV_OPER);
    req(CSP_LV_ADJ);
    for (n = 0; n < 3 * SEC && !aret; n++) @(posedge clk_in);
    `CHK("autoret", 1'b1, n >= SEC - 2 && n < 3 * SEC)
    $display("test levels done");
    p.wr(CSP_REG_SETUP, 32'h19, 1'b0);
    `CHK("dp_timer", 1'b0, dpv)
    p.wr(CSP_REG_SETUP, 32'h18, 1'b0);
    `CHK("dp_count", 1'b1, dpv)
    `CHK("dp_pos", 2'h3, dpp)
    k_r <= 1'b1;
    @(posedge clk_in);
    k_r <= 1'b0;
    @(posedge clk_in);
    `CHK("dp_right", 2'h2, dpp)
    k_l <= 1'b1;
    @(posedge clk_in);
    k_l <= 1'b0;
    @(posedge clk_in);
    `CHK("dp_left", 2'h3, dpp)
    ps = 16'(1 + $urandom % 9999);
    p.wr(CSP_REG_PRESCALE, {16'h0, ps}, 1'b0);
    n = 1 + $urandom % 6;
    pulse(n);
    `CHK("count", 16'(n * ps), cnt)
    `CHK("total", 27'(n), tot)
    gate <= 1'b1;
    repeat (6) @(posedge clk_in);
    pulse(3);
    `CHK("gated", 16'(n * ps), cnt)
    gate <= 1'b0;
    k_rst <= 1'b1;
    @(posedge clk_in);
    k_rst <= 1'b0;
    repeat (2) @(posedge clk_in);
    `CHK("rst_cnt", 16'h0, cnt)
    `CHK("rst_tot", 27'h0, tot)
    $display("test count done");
    goto_prot();
    p.wr(CSP_REG_PROTECT, 32'h33, 1'b0);
    `CHK("adj_vis", 1'b0, adjv)
    `CHK("oth_vis", 1'b0, othv)
    `CHK("pv_edit", 1'b0, pve)
    req(CSP_LV_OPER);
    pulse(2);
    k_rst <= 1'b1;
    @(posedge clk_in);
    k_rst <= 1'b0;
    repeat (2) @(posedge clk_in);
    `CHK("rst_prot", 16'(2 * ps), cnt)
    p.wr(CSP_REG_PRESCALE, 32'h1, 1'b0);
    p.wr(CSP_REG_PRESCALE, 32'h2, 1'b1);
    p.rd(CSP_REG_PRESCALE, 1'b1, d);
    `CHK("ps_keep", {16'h0, ps}, d)
    $display("test protect done");
    close_out();
  end
endmodule : tb_top
